// *** verilog/podt_params.svh ***
// constants of the protection operate-delay timer
`ifndef PODT_PARAMS_SVH
`define PODT_PARAMS_SVH

// ----------------------------------------------------------------
// setting steps and timing
// ----------------------------------------------------------------
// fixed delay step is 0.005 s, expressed in microseconds
`define PODT_STEP_US 32'h0000_1388
// 1800 s expressed in 0.005 s steps
`define PODT_MAX_STEPS 19'h5_7E40
// 1.0 in Q16.16
`define PODT_ONE_Q16 32'h0001_0000
// about 2^26 / 10000, turns 1e-4 units into a plain factor
`define PODT_RECIP_1E4 55'h00_0000_0000_1A37
`define PODT_RECIP_SHIFT 26
`define PODT_DIV_STEPS 6'h31

// ----------------------------------------------------------------
// reset values of the settings
// ----------------------------------------------------------------
`define PODT_DEF_STEPS 19'h0_0008
`define PODT_DEF_DIAL 12'h005
`define PODT_DEF_A 22'h00_035C
`define PODT_DEF_B 22'h00_073A
`define PODT_DEF_C 22'h00_00C8

// ----------------------------------------------------------------
// curve constants, units of 0.0001
// ----------------------------------------------------------------
`define PODT_IEC_NRM_A 22'h00_0578
`define PODT_IEC_NRM_B 22'h00_00C8
`define PODT_IEC_EXT_A 22'h0C_3500
`define PODT_IEC_EXT_B 22'h00_4E20
`define PODT_IEC_VRY_A 22'h02_0F58
`define PODT_IEC_VRY_B 22'h00_2710
`define PODT_IEC_LNG_A 22'h12_4F80
`define PODT_IEC_LNG_B 22'h00_2710
`define PODT_ANSI_NRM_A 22'h01_5CFC
`define PODT_ANSI_NRM_B 22'h00_0705
`define PODT_ANSI_NRM_C 22'h00_51CC
`define PODT_ANSI_VRY_A 22'h00_9934
`define PODT_ANSI_VRY_B 22'h00_03D6
`define PODT_ANSI_EXT_A 22'h00_DC50
`define PODT_ANSI_EXT_B 22'h00_00F3
`define PODT_ANSI_LNG_A 22'h00_DB4C
`define PODT_ANSI_LNG_B 22'h00_5564
`define PODT_ANSI_LNG_C 22'h00_2710
`define PODT_IEEE_MOD_A 22'h00_0203
`define PODT_IEEE_MOD_B 22'h00_0474
`define PODT_IEEE_MOD_C 22'h00_00C8
`define PODT_IEEE_VRY_A 22'h02_FE04
`define PODT_IEEE_VRY_B 22'h00_132E
`define PODT_IEEE_EXT_A 22'h04_4D90
`define PODT_IEEE_EXT_B 22'h00_04C1
`define PODT_EXP2_C 22'h00_4E20

`endif

// *** verilog/podt_pkg.sv ***
// types of the protection operate-delay timer
`default_nettype none
package podt_pkg;

    typedef enum logic {
        fixed_delay_mode = 1'b0,
        inverse_curve_mode = 1'b1
    } podt_delay_type_t;

    typedef enum logic {
        iec_series = 1'b0,
        ieee_series = 1'b1
    } podt_series_t;

    typedef enum logic [2:0] {
        iec_normal_inverse_curve = 3'h0,
        iec_extreme_inverse_curve = 3'h1,
        iec_very_inverse_curve = 3'h2,
        iec_long_time_inverse_curve = 3'h3,
        iec_param_curve = 3'h4
    } podt_iec_curve_t;

    typedef enum logic [2:0] {
        ansi_normal_inverse_curve = 3'h0,
        ansi_very_inverse_curve = 3'h1,
        ansi_extreme_inverse_curve = 3'h2,
        ansi_long_time_inverse_curve = 3'h3,
        ieee_moderate_inverse_curve = 3'h4,
        ieee_very_inverse_curve = 3'h5,
        ieee_extreme_inverse_curve = 3'h6,
        ieee_param_curve = 3'h7
    } podt_ieee_curve_t;

    typedef enum logic [1:0] {
        calc_idle = 2'b00,
        calc_power = 2'b01,
        calc_divide = 2'b10,
        calc_finish = 2'b11
    } podt_calc_state_t;

    typedef struct packed {
        podt_delay_type_t delay_type;
        podt_series_t curve_series;
        podt_iec_curve_t iec_curve;
        podt_ieee_curve_t ieee_curve;
        logic [18:0] fixed_delay_steps;
        logic [11:0] time_dial;
        logic [21:0] param_a;
        logic [21:0] param_b;
        logic [21:0] param_c;
    } podt_cfg_t;

    typedef struct packed {
        logic [21:0] a;
        logic [21:0] b;
        logic [21:0] c;
    } podt_curve_t;

endpackage : podt_pkg
`default_nettype wire

// *** verilog/podt_curve_rom.sv ***
// tabulated curve constants, registered read
`timescale 1ns/10ps
`default_nettype none
`include "podt_params.svh"

module podt_curve_rom
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] curve_sel,
    output podt_pkg::podt_curve_t curve_q
);

    podt_pkg::podt_curve_t curve_d;

    // ----------------------------------------------------------------
    // lookup, msb selects the ieee family
    // ----------------------------------------------------------------
    always_comb
    begin
        curve_d = '0;
        unique case (curve_sel)
            4'h0: curve_d = {`PODT_IEC_NRM_A, `PODT_IEC_NRM_B, 22'h00_0000};
            4'h1: curve_d = {`PODT_IEC_EXT_A, `PODT_IEC_EXT_B, 22'h00_0000};
            4'h2: curve_d = {`PODT_IEC_VRY_A, `PODT_IEC_VRY_B, 22'h00_0000};
            4'h3: curve_d = {`PODT_IEC_LNG_A, `PODT_IEC_LNG_B, 22'h00_0000};
            4'h8: curve_d = {`PODT_ANSI_NRM_A, `PODT_ANSI_NRM_B,
                             `PODT_ANSI_NRM_C};
            4'h9: curve_d = {`PODT_ANSI_VRY_A, `PODT_ANSI_VRY_B,
                             `PODT_EXP2_C};
            4'hA: curve_d = {`PODT_ANSI_EXT_A, `PODT_ANSI_EXT_B,
                             `PODT_EXP2_C};
            4'hB: curve_d = {`PODT_ANSI_LNG_A, `PODT_ANSI_LNG_B,
                             `PODT_ANSI_LNG_C};
            4'hC: curve_d = {`PODT_IEEE_MOD_A, `PODT_IEEE_MOD_B,
                             `PODT_IEEE_MOD_C};
            4'hD: curve_d = {`PODT_IEEE_VRY_A, `PODT_IEEE_VRY_B,
                             `PODT_EXP2_C};
            4'hE: curve_d = {`PODT_IEEE_EXT_A, `PODT_IEEE_EXT_B,
                             `PODT_EXP2_C};
            // parametric and unused codes read zero; parametric constants come from settings
            default: curve_d = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            curve_q <= '0;
        else
            curve_q <= curve_d;
    end

endmodule : podt_curve_rom
`default_nettype wire

// *** verilog/podt_timer.sv ***
// operate-delay timer of one protection stage
`timescale 1ns/10ps
`default_nettype none
`include "podt_params.svh"

// Functional notes
// - instant mode trips together with start
// - fixed mode trips after delay, magnitude ignored
// - fixed count runs only while pick-up holds
// - inverse delay computed from current ratio
// - fixed delay is minimum time in inverse
// - delay type selects mode, resets fixed
// - fixed delay in 0.005 s steps, 0.040 default
// - zero fixed delay means instantaneous operation in fixed mode
// - nonzero delay up to 1800 s delays stage
// - series picks IEC or IEEE, default IEC
// - IEC normal, extreme, very, long-time, param curves
// - IEC param uses settable A and B
// - IEEE family seven curves plus param
// - IEEE param uses settable A, B, C
// - time dial 0.01 steps, default 0.05
// - constant A 0.0001 steps, default 0.0860
// - constant B 0.0001 steps, default 0.1850
// - constant C 0.0001 steps, default 0.0200
// - IEEE delay k times A/(r^C-1)+B
// - IEC tabulated constants A and B
// - IEEE/ANSI tabulated constants A, B, C
module podt_timer
#(
    parameter logic [31:0] TICK_US = `PODT_STEP_US
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic program_tick,
    input wire logic pickup_active,
    input wire logic [15:0] current_ratio,
    input wire logic cfg_load,
    input wire podt_pkg::podt_cfg_t cfg_in,
    output podt_pkg::podt_cfg_t cfg_q,
    output logic start_out,
    output logic trip_out,
    output logic [31:0] operate_delay_us
);

    // ----------------------------------------------------------------
    // settings
    // ----------------------------------------------------------------
    localparam podt_pkg::podt_cfg_t CFG_RESET = '{
        delay_type: podt_pkg::fixed_delay_mode,
        curve_series: podt_pkg::iec_series,
        iec_curve: podt_pkg::iec_normal_inverse_curve,
        ieee_curve: podt_pkg::ansi_normal_inverse_curve,
        fixed_delay_steps: `PODT_DEF_STEPS,
        time_dial: `PODT_DEF_DIAL,
        param_a: `PODT_DEF_A,
        param_b: `PODT_DEF_B,
        param_c: `PODT_DEF_C
    };

    podt_pkg::podt_cfg_t cfg_d;

    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_load)
        begin
            cfg_d = cfg_in;
            // longest fixed delay is 1800 s
            if (cfg_in.fixed_delay_steps > `PODT_MAX_STEPS)
                cfg_d.fixed_delay_steps = `PODT_MAX_STEPS;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_q <= CFG_RESET;
        else
            cfg_q <= cfg_d;
    end

    logic is_ieee;
    logic is_param;
    logic inverse_on;
    logic [31:0] floor_us;

    assign is_ieee = (cfg_q.curve_series == podt_pkg::ieee_series);
    assign is_param = is_ieee ?
        (cfg_q.ieee_curve == podt_pkg::ieee_param_curve) :
        (cfg_q.iec_curve == podt_pkg::iec_param_curve);
    assign inverse_on = (cfg_q.delay_type == podt_pkg::inverse_curve_mode);
    assign floor_us = 32'(cfg_q.fixed_delay_steps) * `PODT_STEP_US;

    // ----------------------------------------------------------------
    // curve constants
    // ----------------------------------------------------------------
    podt_pkg::podt_curve_t rom_q;
    podt_pkg::podt_curve_t coef;
    logic [2:0] curve_code;

    assign curve_code = is_ieee ? 3'(cfg_q.ieee_curve) : 3'(cfg_q.iec_curve);

    podt_curve_rom podt_curve_rom_i
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .curve_sel({is_ieee, curve_code}),
        .curve_q(rom_q)
    );

    // parametric curves take the user constants
    assign coef = is_param ?
        {cfg_q.param_a, cfg_q.param_b, cfg_q.param_c} : rom_q;

    // ----------------------------------------------------------------
    // power of the ratio, piecewise linear log2 and exp2
    // ----------------------------------------------------------------
    // error stays within a few percent; cheaper than a real log unit
    function automatic logic [19:0] podt_log2(input logic [15:0] r);
        logic [3:0] m;
        logic [15:0] sh;
        m = 4'h8;
        for (int i = 0; i < 16; i++)
            if (r[i])
                m = 4'(i);
        sh = r << (4'hF - m);
        return {4'(m - 4'h8), sh[14:0], 1'b0};
    endfunction : podt_log2

    logic [15:0] ratio_clamped;
    logic [21:0] expo;
    logic [54:0] e_full;
    logic [28:0] e_val;
    logic [31:0] pwr;
    logic [33:0] k_a;
    logic [33:0] k_b;

    // below pick-up the ratio counts as one
    assign ratio_clamped = (current_ratio < 16'h0100) ? 16'h0100 :
                           current_ratio;
    assign expo = is_ieee ? coef.c : coef.b;
    assign e_full = 55'(podt_log2(ratio_clamped)) * 55'(expo) *
                    `PODT_RECIP_1E4;
    assign e_val = e_full[`PODT_RECIP_SHIFT +: 29];
    assign pwr = (e_val[28:16] > 13'h000E) ? 32'hFFFF_FFFF :
                 (32'({1'b1, e_val[15:0]}) << e_val[19:16]);
    // dial in 0.01 and constants in 1e-4 give microseconds directly
    assign k_a = 34'(cfg_q.time_dial) * 34'(coef.a);
    assign k_b = 34'(cfg_q.time_dial) * 34'(coef.b);

    // ----------------------------------------------------------------
    // delay computation
    // ----------------------------------------------------------------
    podt_pkg::podt_calc_state_t calc_q;
    podt_pkg::podt_calc_state_t calc_d;
    logic [49:0] quo_q;
    logic [49:0] quo_d;
    logic [31:0] rem_q;
    logic [31:0] rem_d;
    logic [31:0] dvs_q;
    logic [31:0] dvs_d;
    logic [33:0] add_q;
    logic [33:0] add_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [31:0] target_q;
    logic [31:0] target_d;
    logic [32:0] rem_sh;
    logic [31:0] quo_sat;
    logic [34:0] total;

    assign rem_sh = {rem_q, quo_q[49]};
    assign quo_sat = (|quo_q[49:32]) ? 32'hFFFF_FFFF : quo_q[31:0];
    assign total = 35'(quo_sat) + 35'(add_q);

    always_comb
    begin
        calc_d = calc_q;
        quo_d = quo_q;
        rem_d = rem_q;
        dvs_d = dvs_q;
        add_d = add_q;
        cnt_d = cnt_q;
        target_d = target_q;
        unique case (calc_q)
            podt_pkg::calc_idle:
            begin
                // recomputed back to back so the ratio is tracked
                if (inverse_on)
                    calc_d = podt_pkg::calc_power;
            end
            podt_pkg::calc_power:
            begin
                quo_d = {k_a, 16'h0000};
                rem_d = '0;
                cnt_d = `PODT_DIV_STEPS;
                if (is_ieee)
                begin
                    dvs_d = pwr - `PODT_ONE_Q16;
                    add_d = k_b;
                end
                else
                begin
                    dvs_d = pwr;
                    add_d = '0;
                end
                if (is_ieee && (pwr <= `PODT_ONE_Q16))
                begin
                    target_d = 32'hFFFF_FFFF;
                    calc_d = podt_pkg::calc_idle;
                end
                else
                    calc_d = podt_pkg::calc_divide;
            end
            podt_pkg::calc_divide:
            begin
                if (rem_sh >= {1'b0, dvs_q})
                begin
                    rem_d = 32'(rem_sh - {1'b0, dvs_q});
                    quo_d = {quo_q[48:0], 1'b1};
                end
                else
                begin
                    rem_d = rem_sh[31:0];
                    quo_d = {quo_q[48:0], 1'b0};
                end
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h00)
                    calc_d = podt_pkg::calc_finish;
            end
            podt_pkg::calc_finish:
            begin
                target_d = (|total[34:32]) ? 32'hFFFF_FFFF : total[31:0];
                calc_d = podt_pkg::calc_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            calc_q <= podt_pkg::calc_idle;
            quo_q <= '0;
            rem_q <= '0;
            dvs_q <= '0;
            add_q <= '0;
            cnt_q <= '0;
            target_q <= 32'hFFFF_FFFF;
        end
        else
        begin
            calc_q <= calc_d;
            quo_q <= quo_d;
            rem_q <= rem_d;
            dvs_q <= dvs_d;
            add_q <= add_d;
            cnt_q <= cnt_d;
            target_q <= target_d;
        end
    end

    // ----------------------------------------------------------------
    // operate timer
    // ----------------------------------------------------------------
    logic [31:0] elapsed_q;
    logic [31:0] elapsed_d;
    logic [31:0] delay_eff;
    logic [32:0] elapsed_sum;
    logic start_d;
    logic trip_d;
    logic [31:0] oper_d;

    assign elapsed_sum = {1'b0, elapsed_q} + {1'b0, TICK_US};
    // minimum time floor under the inverse curve
    assign delay_eff = !inverse_on ? floor_us :
                       (target_q > floor_us) ? target_q : floor_us;

    always_comb
    begin
        start_d = start_out;
        trip_d = trip_out;
        elapsed_d = elapsed_q;
        oper_d = delay_eff;
        if (program_tick)
        begin
            start_d = pickup_active;
            // a zero delay trips on the very start evaluation
            trip_d = pickup_active && (elapsed_q >= delay_eff);
            if (!pickup_active)
                elapsed_d = '0;
            else if (elapsed_sum[32])
                elapsed_d = 32'hFFFF_FFFF;
            else
                elapsed_d = elapsed_sum[31:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            start_out <= 1'b0;
            trip_out <= 1'b0;
            elapsed_q <= '0;
            operate_delay_us <= '0;
        end
        else
        begin
            start_out <= start_d;
            trip_out <= trip_d;
            elapsed_q <= elapsed_d;
            operate_delay_us <= oper_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_calc_begin;
        calc_q == podt_pkg::calc_power && !(is_ieee && pwr <= `PODT_ONE_Q16);
    endsequence
    sequence s_calc_end;
        ##51 calc_q == podt_pkg::calc_finish
        ##1 calc_q == podt_pkg::calc_idle;
    endsequence

    a_instant_trip: assert property (program_tick && pickup_active &&
        !inverse_on && floor_us == 32'h0000_0000 |=> trip_out && start_out)
        else $error("instant stage did not trip with start");
    a_drop_clears: assert property (program_tick && !pickup_active
        |=> !trip_out && !start_out && elapsed_q == 32'h0000_0000)
        else $error("pick-up loss did not clear the timer");
    a_fixed_expiry: assert property (program_tick && pickup_active &&
        !inverse_on && elapsed_q >= floor_us |=> trip_out)
        else $error("fixed delay elapsed without trip");
    a_fixed_early: assert property (program_tick && pickup_active &&
        !inverse_on && elapsed_q < floor_us |=> !trip_out)
        else $error("fixed delay tripped early");
    a_floor_hold: assert property (program_tick && inverse_on &&
        elapsed_q < floor_us |=> !trip_out)
        else $error("inverse trip ahead of minimum time");
    a_count_step: assert property (program_tick && pickup_active &&
        !elapsed_q[31] |=> elapsed_q == $past(elapsed_q) + TICK_US)
        else $error("counter did not advance by one tick");
    a_count_idle: assert property (!program_tick |=>
        $stable(elapsed_q) && $stable(trip_out))
        else $error("timer moved without a tick");
    a_calc_length: assert property (s_calc_begin |-> s_calc_end)
        else $error("delay computation length wrong");
    a_fixed_no_calc: assert property (!inverse_on &&
        calc_q == podt_pkg::calc_idle |=> calc_q == podt_pkg::calc_idle)
        else $error("curve computed outside inverse mode");

endmodule : podt_timer
`default_nettype wire

// *** tb/podt_far_model.sv ***
// far-side model: pick-up logic and trip output matrix
`timescale 1ns/10ps
`default_nettype none

module podt_far_model
#(
    parameter int TICK_GAP = 4
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic pick_level,
    input wire logic [15:0] ratio_level,
    input wire logic trip_in,
    output logic program_tick,
    output logic pickup_active,
    output logic [15:0] current_ratio,
    output logic [7:0] trip_count
);
    int gap;
    logic trip_seen;

    assign pickup_active = pick_level;
    assign current_ratio = ratio_level;

    // ----------------------------------------------------------------
    // program cycle
    // ----------------------------------------------------------------
    // ticks move on the falling edge, clear of the sampling edge
    always @(negedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap <= 0;
            program_tick <= 1'b0;
        end
        else
        begin
            gap <= (gap == TICK_GAP - 1) ? 0 : gap + 1;
            program_tick <= (gap == TICK_GAP - 1);
        end
    end

    // ----------------------------------------------------------------
    // output matrix
    // ----------------------------------------------------------------
    // counts trip onsets only, a held trip is one event
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trip_seen <= 1'b0;
            trip_count <= 8'h00;
        end
        else
        begin
            trip_seen <= trip_in;
            if (trip_in && !trip_seen)
                trip_count <= trip_count + 8'h01;
        end
    end
endmodule : podt_far_model

`default_nettype wire

// *** tb/podt_timer_bench.sv ***
// self-checking bench of the operate-delay timer
`timescale 1ns/10ps
`default_nettype none

module podt_timer_bench;
    localparam int CEILING = 20000;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_load = 1'b0;
    logic pick_level = 1'b0;
    logic [15:0] ratio_level = 16'h1000;
    podt_pkg::podt_cfg_t cfg_in;
    podt_pkg::podt_cfg_t cfg_q;
    podt_pkg::podt_cfg_t def_cfg;
    podt_pkg::podt_cfg_t c;
    logic program_tick;
    logic pickup_active;
    logic start_out;
    logic trip_out;
    logic [15:0] current_ratio;
    logic [31:0] operate_delay_us;
    logic [7:0] trip_count;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    real a;
    real b;
    real cc;
    real want;
    real got;
    // series, code, A, B, C (units of 0.0001), tolerance in percent
    int tbl [13][6] = '{'{0, 0, 1400, 200, 0, 8}, '{0, 1, 800000, 20000, 0, 8},
        '{0, 2, 135000, 10000, 0, 8}, '{0, 3, 1200000, 10000, 0, 8},
        '{0, 4, 5000, 10000, 0, 8}, '{1, 0, 89340, 1797, 20940, 8},
        '{1, 1, 39220, 982, 20000, 8}, '{1, 2, 56400, 243, 20000, 8},
        '{1, 3, 56140, 21860, 10000, 8}, '{1, 4, 515, 1140, 200, 50},
        '{1, 5, 196100, 4910, 20000, 8}, '{1, 6, 282000, 1217, 20000, 8},
        '{1, 7, 10000, 5000, 20000, 8}};

    always #10 core_clk = ~core_clk;

    podt_timer #(.TICK_US(32'h0000_1388)) podt_timer_i (.core_clk(core_clk),
        .reset_n(reset_n), .program_tick(program_tick),
        .pickup_active(pickup_active), .current_ratio(current_ratio),
        .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg_q(cfg_q),
        .start_out(start_out), .trip_out(trip_out),
        .operate_delay_us(operate_delay_us));

    podt_far_model podt_far_model_i (.core_clk(core_clk), .reset_n(reset_n),
        .pick_level(pick_level), .ratio_level(ratio_level),
        .trip_in(trip_out), .program_tick(program_tick),
        .pickup_active(pickup_active), .current_ratio(current_ratio),
        .trip_count(trip_count));

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [127:0] exp,
        input logic [127:0] seen);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // a load may land mid-division: two full curve passes to settle
    task automatic load(input podt_pkg::podt_cfg_t v);
        cfg_in = v;
        cfg_load = 1'b1;
        @(negedge core_clk);
        cfg_load = 1'b0;
        repeat (120) @(negedge core_clk);
    endtask : load

    task automatic step(input logic pick, input logic es, input logic et);
        int g;
        g = 0;
        pick_level = pick;
        do
        begin
            @(posedge core_clk);
            g++;
        end
        while (program_tick !== 1'b1 && g < 50);
        @(negedge core_clk);
        chk("start_out", {127'h0, es}, {127'h0, start_out});
        chk("trip_out", {127'h0, et}, {127'h0, trip_out});
    endtask : step

    task automatic run(input int n, input int trip_at);
        for (int i = 0; i < n; i++)
            step(1'b1, 1'b1, i >= trip_at);
        step(1'b0, 1'b0, 1'b0);
    endtask : run

    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == CEILING)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        def_cfg = '{podt_pkg::fixed_delay_mode, podt_pkg::iec_series,
            podt_pkg::iec_normal_inverse_curve,
            podt_pkg::ansi_normal_inverse_curve, 19'h0_0008, 12'h005,
            22'h00_035C, 22'h00_073A, 22'h00_00C8};
        cfg_in = def_cfg;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("cfg_q", def_cfg, cfg_q);
        chk("param_a", 22'h00_035C, cfg_q.param_a);
        chk("param_b", 22'h00_073A, cfg_q.param_b);
        chk("param_c", 22'h00_00C8, cfg_q.param_c);
        chk("delay", 32'h0000_9C40, operate_delay_us);
        // large ratio must not shorten the fixed delay
        run(10, 8);
        chk("trip_count", 8'h01, trip_count);
        run(5, 99);
        run(9, 8);
        c = def_cfg;
        c.fixed_delay_steps = 19'h0_0000;
        load(c);
        chk("delay", 32'h0000_0000, operate_delay_us);
        run(2, 0);
        c.fixed_delay_steps = 19'h0_0001;
        load(c);
        run(3, 1);
        c.fixed_delay_steps = 19'h5_7E41;
        load(c);
        chk("steps", 19'h5_7E40, cfg_q.fixed_delay_steps);
        chk("delay", 32'h6B49_D200, operate_delay_us);
        // default dial, ratio 4: about 6.8 ms, trips on third tick
        ratio_level = 16'h0400;
        c = def_cfg;
        c.delay_type = podt_pkg::inverse_curve_mode;
        c.fixed_delay_steps = 19'h0_0000;
        load(c);
        run(4, 2);
        c.fixed_delay_steps = 19'h0_0004;
        load(c);
        chk("delay", 32'h0000_4E20, operate_delay_us);
        run(6, 4);
        for (int i = 0; i < 13; i++)
        begin
            c = def_cfg;
            c.delay_type = podt_pkg::inverse_curve_mode;
            c.fixed_delay_steps = 19'h0_0000;
            c.time_dial = 12'h064;
            c.curve_series = podt_pkg::podt_series_t'(tbl[i][0]);
            c.iec_curve = podt_pkg::podt_iec_curve_t'(tbl[i][1]);
            c.ieee_curve = podt_pkg::podt_ieee_curve_t'(tbl[i][1]);
            // tabulated curves keep default constants, so misuse shows
            if (tbl[i][1] == (tbl[i][0] == 1 ? 7 : 4))
            begin
                c.param_a = 22'(tbl[i][2]);
                c.param_b = 22'(tbl[i][3]);
                c.param_c = 22'(tbl[i][4]);
            end
            load(c);
            a = tbl[i][2] / 10000.0;
            b = tbl[i][3] / 10000.0;
            cc = tbl[i][4] / 10000.0;
            if (tbl[i][0] == 0)
                want = 1.0e6 * a / $pow(4.0, b);
            else
                want = 1.0e6 * (a / ($pow(4.0, cc) - 1.0) + b);
            got = real'(operate_delay_us);
            checked++;
            if ((^operate_delay_us) === 1'bx ||
                got < want * (100 - tbl[i][5]) / 100.0 ||
                got > want * (100 + tbl[i][5]) / 100.0)
            begin
                num_errors++;
                $display("MISMATCH curve %0d expected %0d seen %0d", i,
                    int'(want), operate_delay_us);
            end
        end
        print_verdict();
    end
endmodule : podt_timer_bench

`default_nettype wire
